/* File: hdl/spm_ctrl_regs.vh */
// Register offsets, field positions and timing counts of the self-program controller
`ifndef SPM_CTRL_REGS_VH
`define SPM_CTRL_REGS_VH

// Byte address of the control register on the APB bus
`define CTRL_OFFSET      8'h68
`define CTRL_RESET       8'h00

// Control register field positions
`define BIT_IRQ_EN       7
`define BIT_BUSY         6
`define BIT_RSVD         5
`define BIT_REENABLE     4
`define BIT_LOCKSET      3
`define BIT_PAGE_WRITE_CMD        2
`define BIT_PAGE_ERASE_CMD        1
`define BIT_STEN         0

// Accepted command patterns in the low five bits
`define PAT_REENABLE     5'h11
`define PAT_LOCKSET      5'h09
`define PAT_PAGE_WRITE_CMD        5'h05
`define PAT_PAGE_ERASE_CMD        5'h03
`define PAT_FILL         5'h01

// Arming windows in clock cycles
`define STORE_WINDOW     3'h4
`define LOAD_WINDOW      3'h3

// Application reset address
`define APP_RESET_ADDR   16'h0000

`endif

/* File: hdl/arm_timer.v */
// Countdown that arms the store and load instructions after a command write
`timescale 1ns/10ps
module arm_timer (
	input  wire       pclk,     // Bus clock
	input  wire       presetn,  // Async reset, active low
	input  wire       load,     // Command write took effect
	input  wire       stop,     // Instruction accepted, window closes
	output wire       armed,    // Store window open
	output wire       load_ok,  // Load window open
	output wire       expire    // One-cycle pulse on timeout
);
`include "spm_ctrl_regs.vh"

	reg [2:0] cnt_reg;  // Remaining cycles of the window
	reg [2:0] cnt_next; // Next remaining count

	// Reload, stop or count down
	always @* begin
		cnt_next = cnt_reg;
		if (load) begin
			cnt_next = `STORE_WINDOW;
		end else if (stop) begin
			cnt_next = 3'h0;
		end else if (cnt_reg != 3'h0) begin
			cnt_next = cnt_reg - 3'h1;
		end
	end

	// Counter register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 3'h0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign armed   = (cnt_reg != 3'h0);
	// Load window is the first three cycles of the four
	assign load_ok = (cnt_reg > (`STORE_WINDOW - `LOAD_WINDOW));
	assign expire  = (cnt_reg == 3'h1) && !load && !stop;
endmodule // arm_timer

/* File: hdl/page_buffer.v */
// Temporary page buffer with per-word valid bits and registered read
`timescale 1ns/10ps
module page_buffer #(
	parameter WORD_BITS = 7          // Word index width within a page
) (
	input  wire                 pclk,    // Bus clock
	input  wire                 presetn, // Async reset, active low
	input  wire                 wr_en,   // Write one word
	input  wire [WORD_BITS-1:0] wr_idx,  // Word index to write
	input  wire [15:0]          wr_data, // Word to write
	input  wire                 clr,     // Discard whole buffer
	input  wire [WORD_BITS-1:0] rd_idx,  // Word index to read
	output reg  [15:0]          rd_data  // Registered read word
);
	localparam DEPTH = 1 << WORD_BITS;

	reg [15:0]      mem [0:DEPTH-1]; // Word storage
	reg [DEPTH-1:0] valid_reg;       // Word loaded since last clear

	// Storage array, no reset needed thanks to valid bits
	always @(posedge pclk) begin
		if (wr_en && !clr) begin
			mem[wr_idx] <= wr_data;
		end
	end

	// Valid bits, cleared by reset or clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			valid_reg <= {DEPTH{1'b0}};
		end else if (clr) begin
			valid_reg <= {DEPTH{1'b0}};
		end else if (wr_en) begin
			valid_reg[wr_idx] <= 1'b1;
		end
	end

	// Unloaded words read as erased
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data <= 16'hffff;
		end else if (valid_reg[rd_idx]) begin
			rd_data <= mem[rd_idx];
		end else begin
			rd_data <= 16'hffff;
		end
	end
endmodule // page_buffer

/* File: hdl/flash_self_program_control.v */
// Self-programming controller: control register, arming windows, command sequencing
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps

module flash_self_program_control #(
	parameter WORD_BITS      = 7,        // Word index bits within a page
	parameter HALT_PAGE      = 8'he0,    // First page of the halting section
	parameter BOOT_START     = 16'h7000, // Boot loader word address
	parameter ADDR_W         = 8         // APB address width
) (
	input  wire              pclk,            // Clock, 20 MHz
	input  wire              presetn,         // Async reset, active low
	input  wire [ADDR_W-1:0] paddr,           // APB address
	input  wire              psel,            // APB select
	input  wire              penable,         // APB access phase
	input  wire              pwrite,          // APB write
	input  wire [31:0]       pwdata,          // APB write data
	output wire              pready,          // APB ready
	output reg  [31:0]       prdata,          // APB read data
	output wire              pslverr,         // APB error, unmapped address
	input  wire              store_instr,     // Store-to-program-memory strobe
	input  wire              load_instr,      // Load-from-program-memory strobe
	input  wire [15:0]       z_ptr,           // Z pointer
	input  wire [7:0]        r0_data,         // Register R0
	input  wire [7:0]        r1_data,         // Register R1
	input  wire              global_irq_en,   // Global interrupt flag
	input  wire              boot_reset_fuse, // 1 unprogrammed, 0 programmed
	input  wire [7:0]        fuse_low_bits,   // Fuse byte for readback
	input  wire [7:0]        lock_bits,       // Lock byte for readback
	input  wire              flash_done,      // Flash array finished operation
	input  wire [WORD_BITS-1:0] buf_rd_idx,   // Buffer word read by flash array
	output wire [15:0]       buf_rd_data,     // Buffer word to flash array
	output reg               erase_start,     // Pulse: start page erase
	output reg               write_start,     // Pulse: start page write
	output reg               lock_start,      // Pulse: start lock programming
	output reg  [7:0]        lock_data,       // Lock byte to program
	output reg  [15-WORD_BITS-1:0] page_addr, // Latched target page
	output reg  [7:0]        load_data,       // Lock or fuse byte for load
	output reg               load_valid,      // Pulse: load_data is valid
	output wire              section_blocked, // Readable section blocked
	output wire              cpu_stall,       // Halt processor
	output wire              ready_irq,       // Ready interrupt request
	output reg  [15:0]       reset_fetch_addr // First fetch word address
);
`include "spm_ctrl_regs.vh"

	// Flow of one command:
	//  a valid control write loads the command bits and opens the window,
	//  a store in the window starts the command or loads one buffer word,
	//  erase, write and lock keep their bits until the array reports done.
	// Hazard: command writes are refused while an operation runs, so the
	//  latched page and command bits never change under the array.

	localparam PAGE_BITS = 15 - WORD_BITS;

	// Operation states
	localparam ST_IDLE  = 2'd0; // Nothing in flight
	localparam ST_ERASE = 2'd1; // Page erase running
	localparam ST_WRITE = 2'd2; // Page write running
	localparam ST_LOCK  = 2'd3; // Lock programming running

	// Command kinds in the upper four command bits
	localparam CMD_FILL  = 4'h0; // Store-enable alone, buffer word load
	localparam CMD_ERASE = 4'h1; // Page erase
	localparam CMD_WRITE = 4'h2; // Page write
	localparam CMD_LOCK  = 4'h4; // Lock programming or readback
	localparam CMD_REEN  = 4'h8; // Readable section re-enable

	// Reset image of the control register
	localparam [7:0] CTRL_INIT = `CTRL_RESET;

	// Pattern check of the low five bits
	function valid_pattern;
		input [4:0] pat;
		begin
			valid_pattern = (pat == `PAT_REENABLE) || (pat == `PAT_LOCKSET) ||
				(pat == `PAT_PAGE_WRITE_CMD) || (pat == `PAT_PAGE_ERASE_CMD) ||
				(pat == `PAT_FILL);
		end
	endfunction

	// Match of the latched command bits against one command kind
	function cmd_is;
		input [4:0] cmd;  // Latched command bits
		input [3:0] kind; // Wanted command kind
		begin
			cmd_is = (cmd[4:1] == kind);
		end
	endfunction

	reg                 irq_en_reg;     // Ready interrupt enable
	reg                 irq_en_next;
	reg                 busy_reg;       // Section busy flag
	reg                 busy_next;
	reg  [4:0]          cmd_reg;        // Re-enable, lock, write, erase, enable
	reg  [4:0]          cmd_next;
	reg  [1:0]          state_reg;      // Operation state
	reg  [1:0]          state_next;
	reg                 halt_reg;       // Operation targets halting section
	reg                 halt_next;
	reg                 fuse_taken_reg; // Reset vector already captured

	wire                bus_wr;         // Effective APB write
	wire                ctrl_hit;       // Address decodes to control reg
	wire                cmd_write;      // Command bits accepted
	wire                armed;          // Store window open
	wire                load_ok;        // Load window open
	wire                expire;         // Window timed out
	wire                store_hit;      // Store accepted in window
	wire                load_hit;       // Load accepted in window
	wire                buf_load;       // Buffer word write
	wire                buf_clr;        // Buffer clear
	wire [PAGE_BITS-1:0] z_page;        // Page part of pointer
	wire [WORD_BITS-1:0] z_word;        // Word part of pointer
	wire [7:0]          ctrl_value;     // Control register read value
	wire                erase_hit;      // Store starts a page erase
	wire                write_hit;      // Store starts a page write
	wire                lock_hit;       // Store starts lock programming

	assign ctrl_hit  = (paddr == `CTRL_OFFSET);
	assign bus_wr    = psel && penable && pwrite && ctrl_hit;
	// Commands are refused while an operation is in flight
	assign cmd_write = bus_wr && valid_pattern(pwdata[4:0]) &&
		(state_reg == ST_IDLE);

	// Pointer split: word index skips Z0, page above it
	assign z_word = z_ptr[WORD_BITS:1];
	assign z_page = z_ptr[15:WORD_BITS+1];

	assign store_hit = store_instr && armed && cmd_reg[`BIT_STEN];
	assign load_hit  = load_instr && load_ok && cmd_reg[`BIT_STEN] &&
		cmd_reg[`BIT_LOCKSET];
	// Buffer load only when store-enable was written alone
	assign buf_load  = store_hit && cmd_is(cmd_reg, CMD_FILL);
	// Clear on re-enable write, after page write, and reset via module
	assign buf_clr   = (cmd_write && pwdata[`BIT_REENABLE]) ||
		((state_reg == ST_WRITE) && flash_done);

	// Store decode per command kind, shared by pulses and latches
	assign erase_hit = store_hit && cmd_is(cmd_reg, CMD_ERASE);
	assign write_hit = store_hit && cmd_is(cmd_reg, CMD_WRITE);
	assign lock_hit  = store_hit && cmd_is(cmd_reg, CMD_LOCK);

	// Arming window shared by command bit and store-enable
	// Starts at the effective write, cut short by an accepted strobe
	arm_timer u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.load    (cmd_write),
		.stop    (store_hit || load_hit),
		.armed   (armed),
		.load_ok (load_ok),
		.expire  (expire)
	);

	// Temporary page buffer
	// Array side reads words while a page write runs
	page_buffer #(
		.WORD_BITS (WORD_BITS)
	) u_buffer (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (buf_load),
		.wr_idx  (z_word),
		.wr_data ({r1_data, r0_data}),
		.clr     (buf_clr),
		.rd_idx  (buf_rd_idx),
		.rd_data (buf_rd_data)
	);

	// Next-state logic of control bits and operation
	always @* begin
		irq_en_next = irq_en_reg;
		busy_next   = busy_reg;
		cmd_next    = cmd_reg;
		state_next  = state_reg;
		halt_next   = halt_reg;
		// Interrupt enable follows any write to the register
		if (bus_wr) begin
			irq_en_next = pwdata[`BIT_IRQ_EN];
		end
		if (cmd_write) begin
			cmd_next = pwdata[4:0];
		end else if (load_hit) begin
			// Readback done, lock-set and enable auto-clear
			cmd_next = 5'h00;
		end else if (store_hit) begin
			// Store carries out the latched command
			case (cmd_reg[4:1])
				CMD_REEN: begin
					// Re-enable: only reached when idle
					busy_next = 1'b0;
					cmd_next  = 5'h00;
				end
				CMD_LOCK: begin
					// Bits stay set until the array is done
					state_next = ST_LOCK;
				end
				CMD_WRITE: begin
					// Halting page stalls the core, others mark busy
					state_next = ST_WRITE;
					halt_next  = (z_page >= HALT_PAGE);
					busy_next  = (z_page < HALT_PAGE) || busy_reg;
				end
				CMD_ERASE: begin
					// Same split as the page write
					state_next = ST_ERASE;
					halt_next  = (z_page >= HALT_PAGE);
					busy_next  = (z_page < HALT_PAGE) || busy_reg;
				end
				default: begin
					// Buffer load releases the busy section
					busy_next = 1'b0;
					cmd_next  = 5'h00;
				end
			endcase
		end else if (expire && (state_reg == ST_IDLE)) begin
			// Window ran out with no strobe: drop command and enable
			cmd_next = 5'h00;
		end
		// Completion of a flash operation
		if ((state_reg != ST_IDLE) && flash_done) begin
			state_next = ST_IDLE;
			halt_next  = 1'b0;
			cmd_next   = 5'h00;
		end
	end

	// Control state registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en_reg <= CTRL_INIT[`BIT_IRQ_EN];
			busy_reg   <= CTRL_INIT[`BIT_BUSY];
			cmd_reg    <= CTRL_INIT[4:0];
			state_reg  <= ST_IDLE;
			halt_reg   <= 1'b0;
		end else begin
			irq_en_reg <= irq_en_next;
			busy_reg   <= busy_next;
			cmd_reg    <= cmd_next;
			state_reg  <= state_next;
			halt_reg   <= halt_next;
		end
	end

	// Start pulses and latched target, pointer free afterwards
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			erase_start <= 1'b0;
			write_start <= 1'b0;
			lock_start  <= 1'b0;
			lock_data   <= 8'hff;
			page_addr   <= {PAGE_BITS{1'b0}};
		end else begin
			// One-cycle pulses, the cycle after the store
			erase_start <= erase_hit;
			write_start <= write_hit;
			lock_start  <= lock_hit;
			if (lock_hit) begin
				// Only R0 matters, pointer and R1 ignored
				lock_data <= r0_data;
			end
			if (erase_hit || write_hit) begin
				// Page taken once, software may reuse the pointer
				page_addr <= z_page;
			end
		end
	end

	// Lock or fuse readback on load in window
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_data  <= 8'h00;
			load_valid <= 1'b0;
		end else begin
			// Pulse marks the cycle in which load_data is fresh
			load_valid <= load_hit;
			if (load_hit) begin
				// Byte select by pointer bit zero
				load_data <= z_ptr[0] ? lock_bits : fuse_low_bits;
			end
		end
	end

	// Reset fetch address, fuse caught after reset release
	// Sampled once, so a fuse change needs a new reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fuse_taken_reg   <= 1'b0;
			reset_fetch_addr <= `APP_RESET_ADDR;
		end else if (!fuse_taken_reg) begin
			fuse_taken_reg   <= 1'b1;
			// Fuse is only read here, never written
			reset_fetch_addr <= boot_reset_fuse ? `APP_RESET_ADDR : BOOT_START;
		end
	end

	// Read value, reserved bit forced to zero
	assign ctrl_value = {irq_en_reg, busy_reg, 1'b0, cmd_reg};

	// Read data captured in setup phase, zero wait states
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable) begin
			prdata <= ctrl_hit ? {24'h000000, ctrl_value} : 32'h00000000;
		end
	end

	// Zero wait states: every access phase completes at once
	assign pready  = 1'b1;
	// Only the control register is mapped
	assign pslverr = psel && penable && !ctrl_hit;

	// Section blocking and processor stall
	assign section_blocked = busy_reg;
	// Lock programming never stalls the core
	assign cpu_stall = halt_reg && ((state_reg == ST_ERASE) ||
		(state_reg == ST_WRITE));
	// Ready interrupt held while store-enable is clear
	// Drops as soon as a command arms the store
	assign ready_irq = irq_en_reg && global_irq_en && !cmd_reg[`BIT_STEN];
endmodule // flash_self_program_control

/* File: bench/self_prog_assertions.sv */
// Port-level checker of the self-program controller
`timescale 1ns/10ps
module self_prog_assertions #(
	parameter WORD_BITS = 7 // Word index bits within a page
) (
	input wire                      pclk,          // Clock
	input wire                      presetn,       // Reset, active low
	input wire                      store_instr,   // Store strobe
	input wire [15:0]               z_ptr,         // Pointer
	input wire [7:0]                r0_data,       // Low data byte
	input wire [7:0]                lock_bits,     // Lock byte source
	input wire [7:0]                fuse_low_bits, // Fuse byte source
	input wire                      global_irq_en, // Global interrupt flag
	input wire                      flash_done,    // Array finished
	input wire                      erase_start,   // Erase pulse
	input wire                      write_start,   // Write pulse
	input wire                      lock_start,    // Lock pulse
	input wire [7:0]                lock_data,     // Lock byte out
	input wire [15-WORD_BITS-1:0]   page_addr,     // Latched page
	input wire [7:0]                load_data,     // Readback byte
	input wire                      load_valid,    // Readback pulse
	input wire                      cpu_stall,     // Halt request
	input wire                      ready_irq      // Ready interrupt
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_IRQ_GATE: assert property (!global_irq_en |-> !ready_irq)
		else $error("ready irq without global enable");
	AST_ERASE_CAUSE: assert property (erase_start |-> $past(store_instr))
		else $error("erase start without store");
	AST_WRITE_CAUSE: assert property (write_start |-> $past(store_instr))
		else $error("write start without store");
	AST_LOCK_R0: assert property (lock_start |-> lock_data == $past(r0_data))
		else $error("lock byte not taken from low data");
	AST_PAGE_SPLIT: assert property ((erase_start || write_start)
		|-> page_addr == $past(z_ptr[15:WORD_BITS+1])) else $error("page not upper pointer");
	AST_PAGE_HELD: assert property (!(erase_start || write_start)
		|-> $stable(page_addr)) else $error("page moved without start");
	AST_LOAD_SEL: assert property (load_valid |-> load_data ==
		($past(z_ptr[0]) ? $past(lock_bits) : $past(fuse_low_bits))) else $error("bad readback");
	AST_LOAD_PULSE: assert property (load_valid |=> !load_valid)
		else $error("readback pulse too long");
	AST_STALL_END: assert property (flash_done |=> !cpu_stall)
		else $error("stall outlives completion");
	AST_STALL_RISE: assert property ($rose(cpu_stall) |-> erase_start || write_start)
		else $error("stall without operation start");
	COV_ERASE: cover property (erase_start);
	COV_WRITE: cover property (write_start);
	COV_LOCK: cover property (lock_start);
	COV_LOAD: cover property (load_valid);
endmodule // self_prog_assertions

/* File: bench/cpu_core_model.sv */
// Behavioural processor core and flash array facing the controller
`timescale 1ns/10ps
module cpu_core_model (
	input  wire        pclk,        // Clock
	output reg         store_instr, // Store strobe
	output reg         load_instr,  // Load strobe
	output reg  [15:0] z_ptr,       // Pointer
	output reg  [7:0]  r0_data,     // Low data byte
	output reg  [7:0]  r1_data,     // High data byte
	output reg         flash_done   // Array finished
);
	// Quiet core at time zero
	initial begin
		store_instr = 1'b0;
		load_instr = 1'b0;
		z_ptr = 16'h0000;
		r0_data = 8'h00;
		r1_data = 8'h00;
		flash_done = 1'b0;
	end
	// One instruction for one cycle, then stale operands scrambled
	task strobe(input st, input [15:0] z, input [7:0] hi, input [7:0] lo);
		begin
			@(posedge pclk);
			store_instr <= st;
			load_instr <= !st;
			z_ptr <= z;
			r1_data <= hi;
			r0_data <= lo;
			@(posedge pclk);
			store_instr <= 1'b0;
			load_instr <= 1'b0;
			z_ptr <= ~z;
			r1_data <= ~hi;
			r0_data <= ~lo;
		end
	endtask
	// Array completion after n cycles, prompt or slow
	task finish(input integer n);
		begin
			repeat (n) @(posedge pclk);
			flash_done <= 1'b1;
			@(posedge pclk);
			flash_done <= 1'b0;
		end
	endtask
endmodule // cpu_core_model

/* File: bench/tb_top.sv */
// Self-checking bench of the self-program controller
`timescale 1ns/10ps
module tb_top;
	reg         pclk = 1'b0;    // Clock
	reg         presetn = 1'b0; // Reset, active low
	reg  [7:0]  paddr = 8'h00;  // Bus address
	reg         psel = 1'b0;    // Select
	reg         penable = 1'b0; // Access phase
	reg         pwrite = 1'b0;  // Direction
	reg  [31:0] pwdata = 32'h0; // Write data
	reg         gie = 1'b0;     // Global interrupt flag
	reg         fuse = 1'b1;    // Boot reset fuse
	reg  [6:0]  rd_idx = 7'h00; // Buffer read index
	reg  [7:0]  lock_byte = 8'h3c; // Lock byte source
	reg  [7:0]  fuse_byte = 8'h9e; // Fuse byte source
	reg         err_seen = 1'b0;   // Error response of last transfer
	wire        pready, pslverr, store_instr, load_instr, flash_done; // Handshakes
	wire [31:0] prdata;                                           // Read data
	wire [15:0] z_ptr, buf_rd_data, reset_fetch_addr;             // Words
	wire [7:0]  r0_data, r1_data, lock_data, page_addr, load_data; // Bytes
	wire        erase_start, write_start, lock_start, load_valid; // Pulses
	wire        section_blocked, cpu_stall, ready_irq;           // Levels
	integer     n_fail = 0;  // Mismatches
	integer     n_tests = 0; // Comparisons
	integer     i;           // Loop index
	always #25 pclk = ~pclk;
	cpu_core_model core (.pclk(pclk), .store_instr(store_instr), .load_instr(load_instr),
		.z_ptr(z_ptr), .r0_data(r0_data), .r1_data(r1_data), .flash_done(flash_done));
	flash_self_program_control #(.BOOT_START(16'h7000)) flash_self_program_control_inst (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .store_instr(store_instr), .load_instr(load_instr),
		.z_ptr(z_ptr), .r0_data(r0_data), .r1_data(r1_data), .global_irq_en(gie),
		.boot_reset_fuse(fuse), .fuse_low_bits(fuse_byte), .lock_bits(lock_byte),
		.flash_done(flash_done), .buf_rd_idx(rd_idx), .buf_rd_data(buf_rd_data),
		.erase_start(erase_start), .write_start(write_start), .lock_start(lock_start),
		.lock_data(lock_data), .page_addr(page_addr), .load_data(load_data),
		.load_valid(load_valid), .section_blocked(section_blocked), .cpu_stall(cpu_stall),
		.ready_irq(ready_irq), .reset_fetch_addr(reset_fetch_addr));
	// Compare and count
	task check(input [31:0] got, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("Error at %0t: saw %h, wanted %h", $time, got, exp);
			end
		end
	endtask
	// One bus transfer: setup, then access until ready
	task apb(input wr, input [7:0] a, input [7:0] d, output [31:0] q);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= wr;
			paddr <= a;
			pwdata <= {24'h0, d};
			@(posedge pclk);
			penable <= 1'b1;
			do @(posedge pclk); while (pready !== 1'b1);
			q = prdata;
			err_seen = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	// Control register write
	task wr(input [7:0] d);
		reg [31:0] q;
		apb(1'b1, 8'h68, d, q);
	endtask
	// Register read against expected byte
	task rd(input [7:0] a, input [7:0] e);
		reg [31:0] q;
		begin
			apb(1'b0, a, 8'h00, q);
			check(q, {24'h0, e});
		end
	endtask
	// Wait n edges, then let updates settle
	task tick(input integer n);
		begin
			repeat (n) @(posedge pclk);
			#1;
		end
	endtask
	// Buffer word read through the array side
	task peek(input [6:0] idx, input [15:0] e);
		begin
			rd_idx <= idx;
			tick(2);
			check(buf_rd_data, e);
		end
	endtask
	// Counts and verdict
	task tally_and_finish;
		begin
			$display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
			if (n_fail == 0 && n_tests > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	// Hang guard
	initial begin
		#2000000;
		n_fail = n_fail + 1;
		tally_and_finish;
	end
	// Test sequence
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		tick(1);
		check(reset_fetch_addr, 16'h0000);
		rd(8'h68, 8'h00);
		check(err_seen, 1'b0);
		rd(8'h6c, 8'h00);
		check(err_seen, 1'b1);
		for (i = 0; i < 32; i = i + 1)
			if (i != 17 && i != 9 && i != 5 && i != 3 && i != 1) begin
				wr(i[7:0]);
				rd(8'h68, 8'h00);
			end
		wr(8'h61);
		rd(8'h68, 8'h01);
		tick(6);
		rd(8'h68, 8'h00);
		$display("Test reset and refusals done");
		wr(8'h01);
		core.strobe(1'b1, 16'h0007, 8'ha5, 8'h3c);
		rd(8'h68, 8'h00);
		peek(7'h03, 16'ha53c);
		peek(7'h04, 16'hffff);
		wr(8'h03);
		core.strobe(1'b1, 16'h1200, 8'h00, 8'h00);
		tick(1);
		check({section_blocked, cpu_stall, page_addr}, {2'b10, 8'h12});
		rd(8'h68, 8'h43);
		core.finish(20);
		rd(8'h68, 8'h40);
		wr(8'h01);
		core.strobe(1'b1, 16'h0008, 8'h12, 8'h34);
		rd(8'h68, 8'h00);
		wr(8'h03);
		core.strobe(1'b1, 16'h1200, 8'h00, 8'h00);
		core.finish(2);
		wr(8'h11);
		core.strobe(1'b1, 16'h0000, 8'h00, 8'h00);
		rd(8'h68, 8'h00);
		peek(7'h04, 16'hffff);
		$display("Test fill, erase and re-enable done");
		wr(8'h03);
		core.strobe(1'b1, 16'he100, 8'h00, 8'h00);
		tick(1);
		check({section_blocked, cpu_stall}, 2'b01);
		core.finish(9);
		wr(8'h01);
		core.strobe(1'b1, 16'h000a, 8'h5a, 8'hc3);
		wr(8'h05);
		core.strobe(1'b1, 16'he100, 8'h00, 8'h00);
		tick(1);
		check({cpu_stall, page_addr}, 9'h1e1);
		core.finish(5);
		tick(0);
		check(cpu_stall, 1'b0);
		rd(8'h68, 8'h00);
		peek(7'h05, 16'hffff);
		$display("Test halting page write done");
		wr(8'h09);
		core.strobe(1'b1, 16'hffff, 8'h55, 8'hc3);
		tick(1);
		check(lock_data, 8'hc3);
		core.finish(3);
		rd(8'h68, 8'h00);
		wr(8'h09);
		tick(6);
		rd(8'h68, 8'h00);
		wr(8'h09);
		core.strobe(1'b0, 16'h0001, 8'h00, 8'h00);
		tick(0);
		check(load_data, 8'h3c);
		fuse_byte <= 8'h61;
		wr(8'h09);
		core.strobe(1'b0, 16'h0000, 8'h00, 8'h00);
		tick(0);
		check(load_data, 8'h61);
		$display("Test lock and readback done");
		gie <= 1'b1;
		wr(8'h80);
		tick(0);
		check(ready_irq, 1'b1);
		wr(8'h81);
		tick(0);
		check(ready_irq, 1'b0);
		tick(6);
		check(ready_irq, 1'b1);
		@(posedge pclk);
		fuse <= 1'b0;
		presetn <= 1'b0;
		tick(2);
		@(posedge pclk);
		presetn <= 1'b1;
		tick(2);
		check(reset_fetch_addr, 16'h7000);
		check(ready_irq, 1'b0);
		rd(8'h68, 8'h00);
		$display("Test interrupt and boot reset done");
		tally_and_finish;
	end
endmodule // tb_top
bind flash_self_program_control self_prog_assertions #(.WORD_BITS(WORD_BITS)) chk_inst (
	.pclk(pclk), .presetn(presetn), .store_instr(store_instr), .z_ptr(z_ptr),
	.r0_data(r0_data), .lock_bits(lock_bits), .fuse_low_bits(fuse_low_bits),
	.global_irq_en(global_irq_en), .flash_done(flash_done), .erase_start(erase_start),
	.write_start(write_start), .lock_start(lock_start), .lock_data(lock_data),
	.page_addr(page_addr), .load_data(load_data), .load_valid(load_valid),
	.cpu_stall(cpu_stall), .ready_irq(ready_irq));
